// ===== hw/ppc_regs.svh
// Purpose: constants of the pager power-control serial port: command layout, page codes,
//          field positions and power-on values of every control group
// Assumes: included by bare name after ppc_pkg is compiled
// Notes:   definitions only
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// command byte layout
`define PPC_CMD_BITS        8
`define PPC_CMD_DAC_BIT     7
`define PPC_CMD_PAGE_HI     6
`define PPC_CMD_PAGE_LO     5
`define PPC_CMD_DATA_HI     4
`define PPC_CMD_DAC_HI      6

// page pointer codes when the top command bit is 0
`define PPC_PAGE_POWER      2'h0
`define PPC_PAGE_RESERVE    2'h1
`define PPC_PAGE_VOLTAGE    2'h2
`define PPC_PAGE_UNUSED     2'h3

// power page field positions
`define PPC_P0_SWITCH_B     4
`define PPC_P0_SWITCH_A     3
`define PPC_P0_AUX_LDO      2
`define PPC_P0_ANALOG_LDO   1
`define PPC_P0_RUN          0

// reserve page field positions (bit 4 unused)
`define PPC_P1_AUTO_RSV     3
`define PPC_P1_RESERVE      2
`define PPC_P1_FAST_CHG     1
`define PPC_P1_TRICKLE_CHG  0

// power-on values
`define PPC_RST_POWER       5'h00
`define PPC_RST_RESERVE     4'h0
`define PPC_RST_VOLTAGE     5'h0c
`define PPC_RST_DAC         7'h00

// bit counter value once a whole byte is in
`define PPC_BITS_FULL       4'h8

`endif

// ===== hw/ppc_pkg.sv
// Purpose: shared types of the pager power-control serial port
// Assumes: nothing
// Notes:   field order of each page and status struct is the on-wire order, top bit first
`default_nettype none
package ppc_pkg;

  // power page, bit 4 down to bit 0
  typedef struct packed {
    logic sink_switch_b_enable;
    logic sink_switch_a_enable;
    logic aux_ldo_enable;
    logic analog_ldo_enable;
    logic run_select;
  } ppc_power_t;

  // reserve page, bit 3 down to bit 0
  typedef struct packed {
    logic auto_reserve_on_low_cell;
    logic reserve_select;
    logic fast_charge_enable;
    logic trickle_charge_enable;
  } ppc_reserve_t;

  // status nibble, sent top bit first
  typedef struct packed {
    logic chan_two_compare_result;
    logic chan_one_compare_result;
    logic chan_zero_compare_result;
    logic low_cell_flag;
  } ppc_status_t;

  // resolved drives toward the analog blocks
  typedef struct packed {
    logic reserve_regulator_on;
    logic boost_enable;
    logic fast_charge_on;
    logic trickle_charge_on;
    logic sense_power_enable;
  } ppc_drive_t;

  // frame tracking in the system domain, gray along idle-selected-apply; apply back to idle flips both bits
  typedef enum logic [1:0] {
    PPC_IDLE     = 2'b00,
    PPC_SELECTED = 2'b01,
    PPC_APPLY    = 2'b11
  } ppc_frame_t;

endpackage : ppc_pkg
`default_nettype wire

// ===== hw/ppc_sync.sv
// Purpose: three-stage synchroniser with agreement filter, one lane per bit
// Assumes: inputs are levels from another clock or from pins
// Notes:   stage one feeds stage two only; output moves when stages two and three agree
`default_nettype none
module ppc_sync #(
  parameter int unsigned    WIDTH    = 1,
  parameter logic [WIDTH-1:0] INIT   = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      // the filter rejects a value seen by only one late stage
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          s1_q  <= INIT[g];
          s2_q  <= INIT[g];
          s3_q  <= INIT[g];
          out_q <= INIT[g];
        end else begin
          s1_q <= async_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign sync_out[g] = out_q;
    end
  endgenerate

endmodule : ppc_sync
`default_nettype wire

// ===== hw/ppc_serial_ctrl.sv
// Purpose: serial control port and control decode of a single-cell pager power manager
// Assumes: serial clock is its own domain and only runs inside a frame; reset is the
//          supervisor reset output, active high and asynchronous
// Notes:   commands are applied in the system domain once select returns high
//
// Contract
// - run select bit picks run at 1, coast at 0; coast after reset.
// - two regulator enables turn their regulators on at 1; reset clears both.
// - two switch enables turn their sink switches on at 1; reset clears both.
// - either charge bit enables charging; fast charge wins when both set; reset off.
// - reserve bit enables reserve regulator, stops boost, overrides charge and auto reserve.
// - auto reserve bit lets an active low-cell flag start reserve and stop boost.
// - five-bit voltage code, 1.8 V up 0.1 V per step; reset loads 3.0 V.
// - seven-bit threshold code held; reset clears it with converter powered off.
// - both serial directions move most significant bit first.
// - data sampled on serial clock rise, output changes on serial clock fall.
// - top status bit drives out as soon as select falls, with no clock.
// - second status bit appears on fall after first rise, later bits each fall.
// - every operation returns four status bits; host uses dummy writes for status.
// - top bit 0 makes next two bits a page choosing the five-bit group.
// - top bit 1 loads all seven remaining bits into the threshold code.
// - status order channel two, one, zero, low cell; low four bits don't care.
// - an all-zero threshold code powers down converter, comparators and dividers.
// - each command is one byte: page pointer plus five data bits, except converter.
// - page 0 power bits, page 1 reserve bits, page 2 voltage, page 3 unused.
// - supervisor reset returns every control bit to its power-on value.
`default_nettype none
`include "ppc_regs.svh"
module ppc_serial_ctrl #(
  parameter int unsigned SYNC_STAGES = 3
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                clk_link,
  input  wire logic                select_n,
  input  wire logic                serial_in,
  output var  logic                serial_out,
  output var  logic                serial_out_oe,
  input  wire ppc_pkg::ppc_status_t status_pins,
  output var  ppc_pkg::ppc_power_t  power_ctrl,
  output var  ppc_pkg::ppc_reserve_t reserve_ctrl,
  output var  logic [4:0]          out_voltage_code,
  output var  logic [6:0]          threshold_dac_code,
  output var  ppc_pkg::ppc_drive_t  drive,
  output var  ppc_pkg::ppc_status_t status_seen
);

  // ---------------------------------------------------------------------------
  // link domain: everything below up to the system section runs on clk_link
  // ---------------------------------------------------------------------------

  logic [3:0]            bit_cnt_q;
  logic [6:0]            shift_q;
  logic [7:0]            byte_hold_q;
  logic                  byte_tgl_q;
  logic                  out_started_q;
  logic                  out_bit_q;
  logic                  link_clear;
  logic                  byte_done;
  logic                  next_out_bit;
  ppc_pkg::ppc_status_t  snap_q;

  // counter and output stage restart whenever select is high or on reset
  assign link_clear = select_n | reset;
  assign byte_done  = (bit_cnt_q == (`PPC_BITS_FULL - 4'h1));

  // rising edge: count bits, saturating so extra clocks add nothing
  always_ff @(posedge clk_link or posedge link_clear) begin
    if (link_clear) begin
      bit_cnt_q <= 4'h0;
    end else if (bit_cnt_q != `PPC_BITS_FULL) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // rising edge: shift in, top bit first, and hand a full byte over
  always_ff @(posedge clk_link or posedge reset) begin
    if (reset) begin
      shift_q     <= 7'h00;
      byte_hold_q <= 8'h00;
      byte_tgl_q  <= 1'b0;
    end else begin
      shift_q <= {shift_q[5:0], serial_in};
      if (byte_done) begin
        byte_hold_q <= {shift_q, serial_in};
        byte_tgl_q  <= ~byte_tgl_q;
      end
    end
  end

  // status bit due on the next falling edge; bits below the nibble read 0
  assign next_out_bit = (bit_cnt_q == 4'h1) ? snap_q.chan_one_compare_result :
                        (bit_cnt_q == 4'h2) ? snap_q.chan_zero_compare_result :
                        (bit_cnt_q == 4'h3) ? snap_q.low_cell_flag :
                        1'b0;

  // falling edge: output moves only after the first rising edge
  always_ff @(negedge clk_link or posedge link_clear) begin
    if (link_clear) begin
      out_started_q <= 1'b0;
      out_bit_q     <= 1'b0;
    end else if (bit_cnt_q != 4'h0) begin
      out_started_q <= 1'b1;
      out_bit_q     <= next_out_bit;
    end
  end

  // top bit straight from the snapshot while select is low, no clock needed
  assign serial_out    = out_started_q ? out_bit_q
                                       : snap_q.chan_two_compare_result;
  assign serial_out_oe = ~select_n;

  // ---------------------------------------------------------------------------
  // system domain
  // ---------------------------------------------------------------------------

  localparam int unsigned SYNC_W = 6;

  logic [SYNC_W-1:0]     sync_raw;
  logic [SYNC_W-1:0]     sync_val;
  logic                  sel_n_s;
  logic                  tgl_s;
  ppc_pkg::ppc_status_t  status_s;

  // cs idles high, so its lane wakes up high to avoid a false frame start
  assign sync_raw = {select_n, byte_tgl_q, status_pins};

  ppc_sync #(
    .WIDTH (SYNC_W),
    .INIT  (6'h20)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in (sync_raw),
    .sync_out (sync_val)
  );

  assign sel_n_s  = sync_val[5];
  assign tgl_s    = sync_val[4];
  assign status_s = ppc_pkg::ppc_status_t'(sync_val[3:0]);

  // status snapshot: frozen during a frame so the link reads a steady word;
  // a comparator flip within the synchroniser delay of select falling is missed
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      snap_q <= ppc_pkg::ppc_status_t'(4'h0);
    end else if (sel_n_s) begin
      snap_q <= status_s;
    end
  end

  // frame tracking and byte pickup
  ppc_pkg::ppc_frame_t  frame_q;
  ppc_pkg::ppc_frame_t  frame_d;
  logic                 tgl_seen_q;
  logic                 pending_q;
  logic [7:0]           cmd_q;
  logic                 byte_arrived;
  logic                 frame_start;
  logic                 frame_end;

  assign byte_arrived = (tgl_s != tgl_seen_q);
  assign frame_start  = (frame_q == ppc_pkg::PPC_IDLE) & ~sel_n_s;
  assign frame_end    = (frame_q == ppc_pkg::PPC_SELECTED) & sel_n_s;

  // next frame state
  always_comb begin
    frame_d = frame_q;
    case (frame_q)
      ppc_pkg::PPC_IDLE: begin
        if (!sel_n_s) begin
          frame_d = ppc_pkg::PPC_SELECTED;
        end
      end
      ppc_pkg::PPC_SELECTED: begin
        if (sel_n_s) begin
          frame_d = (pending_q | byte_arrived) ? ppc_pkg::PPC_APPLY : ppc_pkg::PPC_IDLE;
        end
      end
      ppc_pkg::PPC_APPLY: begin
        frame_d = ppc_pkg::PPC_IDLE;
      end
      default: begin
        frame_d = ppc_pkg::PPC_IDLE;
      end
    endcase
  end

  // the byte holding register is steady for many system cycles after its toggle,
  // since another byte needs eight more link clocks
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frame_q    <= ppc_pkg::PPC_IDLE;
      tgl_seen_q <= 1'b0;
      pending_q  <= 1'b0;
      cmd_q      <= 8'h00;
    end else begin
      frame_q    <= frame_d;
      tgl_seen_q <= tgl_s;
      if (byte_arrived && !pending_q) begin
        pending_q <= 1'b1;
        cmd_q     <= byte_hold_q;
      end else if (frame_start || (frame_q == ppc_pkg::PPC_APPLY)) begin
        pending_q <= 1'b0;
      end
    end
  end

  // command decode
  logic        do_apply;
  logic        is_dac;
  logic [1:0]  page;
  logic [4:0]  data5;
  logic        wr_power;
  logic        wr_reserve;
  logic        wr_voltage;
  logic        wr_dac;

  assign do_apply   = (frame_q == ppc_pkg::PPC_APPLY) & pending_q;
  assign is_dac     = cmd_q[`PPC_CMD_DAC_BIT];
  assign page       = cmd_q[`PPC_CMD_PAGE_HI:`PPC_CMD_PAGE_LO];
  assign data5      = cmd_q[`PPC_CMD_DATA_HI:0];

  // address decoding by page; the unused page selects nothing
  always_comb begin
    wr_power   = 1'b0;
    wr_reserve = 1'b0;
    wr_voltage = 1'b0;
    wr_dac     = 1'b0;
    if (!do_apply) begin
      wr_dac = 1'b0;
    end else if (is_dac) begin
      wr_dac = 1'b1;
    end else if (page == `PPC_PAGE_POWER) begin
      wr_power = 1'b1;
    end else if (page == `PPC_PAGE_RESERVE) begin
      wr_reserve = 1'b1;
    end else if (page == `PPC_PAGE_VOLTAGE) begin
      wr_voltage = 1'b1;
    end else begin
      wr_dac = 1'b0;
    end
  end

  // control groups; supervisor reset restores the power-on values
  ppc_pkg::ppc_power_t    power_q;
  ppc_pkg::ppc_reserve_t  reserve_q;
  logic [4:0]             volt_q;
  logic [6:0]             dac_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      power_q   <= ppc_pkg::ppc_power_t'(`PPC_RST_POWER);
      reserve_q <= ppc_pkg::ppc_reserve_t'(`PPC_RST_RESERVE);
      volt_q    <= `PPC_RST_VOLTAGE;
      dac_q     <= `PPC_RST_DAC;
    end else begin
      if (wr_power) begin
        power_q <= ppc_pkg::ppc_power_t'(data5);
      end
      if (wr_reserve) begin
        reserve_q <= ppc_pkg::ppc_reserve_t'(data5[`PPC_P1_AUTO_RSV:0]);
      end
      if (wr_voltage) begin
        volt_q <= data5;
      end
      if (wr_dac) begin
        dac_q <= cmd_q[`PPC_CMD_DAC_HI:0];
      end
    end
  end

  // drive resolution: reserve overrides charging and the automatic path
  logic                reserve_on;
  ppc_pkg::ppc_drive_t drive_d;
  ppc_pkg::ppc_drive_t drive_q;

  assign reserve_on = reserve_q.reserve_select |
                      (reserve_q.auto_reserve_on_low_cell & status_s.low_cell_flag);
  assign drive_d.reserve_regulator_on = reserve_on;
  assign drive_d.boost_enable         = ~reserve_on;
  assign drive_d.fast_charge_on       = reserve_q.fast_charge_enable & ~reserve_on;
  assign drive_d.trickle_charge_on    = reserve_q.trickle_charge_enable &
                                        ~reserve_q.fast_charge_enable & ~reserve_on;
  assign drive_d.sense_power_enable   = (dac_q != 7'h00);

  // registered drives; reset leaves boost on and everything else off
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      drive_q <= ppc_pkg::ppc_drive_t'(5'h08);
    end else begin
      drive_q <= drive_d;
    end
  end

  // outputs, all from flip-flops
  assign power_ctrl         = power_q;
  assign reserve_ctrl       = reserve_q;
  assign out_voltage_code   = volt_q;
  assign threshold_dac_code = dac_q;
  assign drive              = drive_q;
  assign status_seen        = snap_q;

  // frame_end is kept for readability of the state flow
  logic unused_ok;
  assign unused_ok = frame_end;

endmodule : ppc_serial_ctrl
`default_nettype wire

// ===== verif/ppc_serial_ctrl_sva.sv
// Purpose: port-level checks of the serial control decode
// Assumes: select_n stays high >= 6 clk_sys cycles between frames
// Notes:   all checks in the system clock domain
`default_nettype none
module ppc_serial_ctrl_sva (
  input wire logic                  clk_sys,
  input wire logic                  reset,
  input wire logic                  select_n,
  input wire logic                  serial_out,
  input wire logic                  serial_out_oe,
  input wire ppc_pkg::ppc_power_t   power_ctrl,
  input wire ppc_pkg::ppc_reserve_t reserve_ctrl,
  input wire logic [4:0]            out_voltage_code,
  input wire logic [6:0]            threshold_dac_code,
  input wire ppc_pkg::ppc_drive_t   drive,
  input wire ppc_pkg::ppc_status_t  status_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // drive lags the control registers by one cycle, so compare only once they settled
  chk_oe_follows_select: assert property (serial_out_oe == !select_n)
    else $error("output enable does not follow select");
  chk_first_status_bit: assert property (!select_n && $past(select_n) |->
    serial_out == status_seen.chan_two_compare_result) else $error("top status bit missing");
  chk_reset_values: assert property ($fell(reset) |-> power_ctrl == 5'h00 &&
    reserve_ctrl == 4'h0 && out_voltage_code == 5'h0c && threshold_dac_code == 7'h00)
    else $error("control values after reset wrong");
  chk_apply_after_frame: assert property ($changed({power_ctrl, reserve_ctrl,
    out_voltage_code, threshold_dac_code}) |-> $past(select_n, 4))
    else $error("control changed inside a frame");
  chk_boost_inverse: assert property (drive.boost_enable == !drive.reserve_regulator_on)
    else $error("boost not inverse of reserve");
  chk_fast_gated: assert property ($stable(reserve_ctrl) |-> drive.fast_charge_on ==
    (reserve_ctrl.fast_charge_enable && !drive.reserve_regulator_on))
    else $error("fast charge drive wrong");
  chk_trickle_gated: assert property ($stable(reserve_ctrl) |-> drive.trickle_charge_on ==
    (reserve_ctrl.trickle_charge_enable && !reserve_ctrl.fast_charge_enable &&
    !drive.reserve_regulator_on)) else $error("trickle charge drive wrong");
  chk_reserve_manual: assert property ($stable(reserve_ctrl) &&
    !reserve_ctrl.auto_reserve_on_low_cell |->
    drive.reserve_regulator_on == reserve_ctrl.reserve_select)
    else $error("reserve drive wrong");
  chk_sense_power: assert property ($stable(threshold_dac_code) |->
    drive.sense_power_enable == (threshold_dac_code != 7'h00))
    else $error("sense power wrong");
endmodule // ppc_serial_ctrl_sva

bind ppc_serial_ctrl ppc_serial_ctrl_sva i_ppc_serial_ctrl_sva (
  .clk_sys(clk_sys), .reset(reset), .select_n(select_n), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .power_ctrl(power_ctrl), .reserve_ctrl(reserve_ctrl),
  .out_voltage_code(out_voltage_code), .threshold_dac_code(threshold_dac_code),
  .drive(drive), .status_seen(status_seen));
`default_nettype wire

// ===== verif/ppc_host_model.sv
// Purpose: host microprocessor acting as serial bus master
// Assumes: go is seen on a clk_sys rise; nbits below 8 makes a short frame
// Notes:   link clock runs only inside frames, 30 ns period
`default_nettype none
module ppc_host_model (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [7:0] cmd,
  input  wire logic [3:0] nbits,
  input  wire logic       serial_out,
  output var  logic       select_n,
  output var  logic       clk_link,
  output var  logic       serial_in,
  output var  logic [3:0] rx,
  output var  logic       done
);
  timeunit 1ns;
  timeprecision 100ps;

  // one frame per go; data changes after a fall so it is settled at the next rise
  initial begin
    int i;
    select_n = 1'b1;
    clk_link = 1'b0;
    serial_in = 1'b0;
    rx = 4'h0;
    done = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        done = 1'b0;
        #1 select_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        for (i = 0; i < int'(nbits); i++) begin
          serial_in = cmd[7-i];
          #15 clk_link = 1'b1;
          if (i < 4) rx[3-i] = serial_out;
          #15 clk_link = 1'b0;
        end
        // released line shows the inverse, never a stale copy
        #5 serial_in = ~serial_in;
        select_n = 1'b1;
        done = 1'b1;
      end
    end
  end
endmodule // ppc_host_model
`default_nettype wire

// ===== verif/tb.sv
// Purpose: self-checking bench of the serial control decode
// Assumes: host model makes every frame; inputs move 1 ns after clk_sys rise
// Notes:   16 idle cycles after each frame cover the apply latency
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  clk_sys = 1'b0;
  logic                  reset = 1'b0;
  logic                  go = 1'b0;
  logic [7:0]            cmd = 8'h00;
  logic [3:0]            nbits = 4'h8;
  ppc_pkg::ppc_status_t  status_pins = 4'h0;
  wire logic             clk_link, select_n, serial_in, serial_out, serial_out_oe, done;
  wire logic [3:0]       rx;
  wire ppc_pkg::ppc_power_t   power_ctrl;
  wire ppc_pkg::ppc_reserve_t reserve_ctrl;
  wire logic [4:0]       out_voltage_code;
  wire logic [6:0]       threshold_dac_code;
  wire ppc_pkg::ppc_drive_t   drive;
  wire ppc_pkg::ppc_status_t  status_seen;
  int                    num_errors = 0;
  int                    samples_checked = 0;

  ppc_serial_ctrl i_ppc_serial_ctrl (.clk_sys(clk_sys), .reset(reset), .clk_link(clk_link),
    .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .status_pins(status_pins), .power_ctrl(power_ctrl),
    .reserve_ctrl(reserve_ctrl), .out_voltage_code(out_voltage_code),
    .threshold_dac_code(threshold_dac_code), .drive(drive), .status_seen(status_seen));
  ppc_host_model i_ppc_host_model (.clk_sys(clk_sys), .go(go), .cmd(cmd), .nbits(nbits),
    .serial_out(serial_out), .select_n(select_n), .clk_link(clk_link),
    .serial_in(serial_in), .rx(rx), .done(done));

  always #2 clk_sys = ~clk_sys;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one host frame, then wait out the apply latency; full frames also check status
  task automatic frame(input logic [7:0] c, input logic [3:0] n);
    int k;
    @(posedge clk_sys);
    #1 cmd = c;
    nbits = n;
    go = 1'b1;
    @(posedge clk_sys);
    #1 go = 1'b0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge clk_sys);
    chk(8'(done), 8'h01);
    repeat (16) @(posedge clk_sys);
    #1 if (n == 4'h8) chk(8'(rx), 8'(status_pins));
    chk(8'(status_seen), 8'(status_pins));
  endtask

  task automatic t_reset_vals();
    chk(8'(power_ctrl), 8'h00);
    chk(8'(reserve_ctrl), 8'h00);
    chk(8'(out_voltage_code), 8'h0c);
    chk(8'(threshold_dac_code), 8'h00);
    chk(8'(drive), 8'h08);
    $display("test reset values done");
  endtask

  // walk one bit through the power page, rotating status so every bit position moves
  task automatic t_power();
    int i;
    for (i = 0; i < 5; i++) begin
      status_pins = 4'(i * 5 + 9);
      frame({3'b000, 5'(1 << i)}, 4'h8);
      chk(8'(power_ctrl), 8'(1 << i));
    end
    frame(8'h1f, 4'h8);
    chk(8'(power_ctrl), 8'h1f);
    $display("test power page done");
  endtask

  task automatic t_volt_dac();
    logic [4:0] v[3] = '{5'h00, 5'h1f, 5'h0c};
    int i;
    for (i = 0; i < 3; i++) begin
      frame({3'b010, v[i]}, 4'h8);
      chk(8'(out_voltage_code), 8'(v[i]));
    end
    frame(8'hd5, 4'h8);
    chk(8'(threshold_dac_code), 8'h55);
    chk(8'(drive.sense_power_enable), 8'h01);
    chk(8'(power_ctrl), 8'h1f);
    frame(8'h80, 4'h8);
    chk(8'(drive.sense_power_enable), 8'h00);
    $display("test voltage and converter done");
  endtask

  // {low cell, page data} against {reserve, boost, fast, trickle}
  task automatic t_reserve();
    logic [5:0] rin[6] = '{6'h01, 6'h03, 6'h07, 6'h28, 6'h08, 6'h11};
    logic [3:0] rexp[6] = '{4'h5, 4'h6, 4'h8, 4'h8, 4'h4, 4'h5};
    int i;
    for (i = 0; i < 6; i++) begin
      status_pins.low_cell_flag = rin[i][5];
      frame({3'b001, rin[i][4:0]}, 4'h8);
      chk(8'(reserve_ctrl), 8'(rin[i][3:0]));
      chk(8'(drive[4:1]), 8'(rexp[i]));
    end
    $display("test reserve and charge done");
  endtask

  task automatic t_refused();
    frame(8'h7f, 4'h8);
    frame(8'h00, 4'h5);
    chk(8'(power_ctrl), 8'h1f);
    chk(8'(reserve_ctrl), 8'h01);
    chk(8'(out_voltage_code), 8'h0c);
    $display("test ignored frames done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence, ending with a supervisor reset in mid-run
  // reset rises after time zero: a declared start value makes no edge for async resets
  initial begin
    #1 reset = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 t_reset_vals();
    t_power();
    t_volt_dac();
    t_reserve();
    t_refused();
    // move voltage and threshold off their power-on values so the reset check bites
    frame(8'h5f, 4'h8);
    chk(8'(out_voltage_code), 8'h1f);
    frame(8'hff, 4'h8);
    chk(8'(threshold_dac_code), 8'h7f);
    #1 reset = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 t_reset_vals();
    summarize();
  end

  // all frames fit well inside this span
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
endmodule // tb
`default_nettype wire
